// file: logic/smsc_clk_gen.sv
// Master serial clock half-period tick generator
`include "smsc_defines.svh"

module smsc_clk_gen (
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       run_i,
   input  wire logic       use_timer_i,
   input  wire logic [1:0] rate_i,
   input  wire logic       timer_i,
   output logic            tick_o
);

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic       timer_prev_q;
   logic       tick_d;

   wire  [2:0] last_cnt  = (rate_i == `SMSC_RATE_DIV2) ? `SMSC_HALF_DIV2 :
                           (rate_i == `SMSC_RATE_DIV4) ? `SMSC_HALF_DIV4 :
                           (rate_i == `SMSC_RATE_DIV8) ? `SMSC_HALF_DIV8 :
                                                         `SMSC_HALF_DIV16;
   wire        div_hit   = (cnt_q == last_cnt);
   wire        timer_hit = timer_i & ~timer_prev_q;

   // Timer output gives one half period per rising edge
   assign tick_d = run_i & (use_timer_i ? timer_hit : div_hit);
   assign cnt_d  = (!run_i || div_hit) ? 3'h0 : cnt_q + 3'h1;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q        <= 3'h0;
         timer_prev_q <= 1'b0;
         tick_o       <= 1'b0;
      end else begin
         cnt_q        <= cnt_d;
         timer_prev_q <= timer_i;
         tick_o       <= tick_d;
      end
   end

endmodule : smsc_clk_gen

// file: logic/smsc_core.sv
// Byte-wide synchronous serial interface, master or slave, with address compare
//
// How it works
// - Control bit 0 enables; reset leaves disabled.
// - Master bits 1-2 divide clock 2/4/8/16.
// - Slave bit 1 is overrun, cleared by zero.
// - Slave bit 2 releases data-out pin.
// - Bit 3 enables compare against match value.
// - Bit 4 shows byte waiting; interrupt requested.
// - Bit 5 selects sampling and driving edges.
// - Bit 6 picks timer or divided clock.
// - Bit 7 selects master, else slave.
// - Slave transfer spans active slave select.
// - Full byte flags, interrupts, keeps receiving.
// - Unread slave buffer overwritten, overrun set.
// - Slave works in STOP, HALT and RUN.
// - Slave clock is input; bit out per bit.
// - Master select via port; write starts transfer.
// - Master byte end flags and interrupts.
// - Compare byte received without driving data.
// - Compared byte silent; mismatch ignores until release.
// - Match wakes device, then normal slave transfer.
// - Reading receive buffer clears ready flag.
// - Ready flag works in both modes.
`include "smsc_defines.svh"

module smsc_core
   import smsc_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   input  smsc_req_t       req_i,
   output logic [7:0]      rdata_o,
   input  wire logic       serial_input_pin_i,
   input  wire logic       serial_clock_pin_i,
   input  wire logic       slave_select_n_i,
   input  wire logic       timer_zero_output_i,
   output smsc_pins_t      pins_o,
   output logic            receive_interrupt_request_o,
   output logic            stop_wake_signal_o
);

   smsc_ctrl_t  ctrl_q;
   smsc_ctrl_t  ctrl_d;
   smsc_state_t st_q;
   smsc_state_t st_d;

   logic [7:0]  match_q;
   logic [7:0]  receive_holding_buffer_q;
   logic [7:0]  sh_q;
   logic        samp_q;
   logic        pend_q;
   logic [2:0]  bits_q;
   logic [3:0]  edges_q;
   logic        sck_q;
   logic        sck_prev_q;
   logic        dout_q;
   logic        dout_oe_q;
   logic        sck_oe_q;
   logic [7:0]  rdata_q;
   logic        irq_q;
   logic        wake_q;
   logic        tick;

   // Register decode
   wire        wr_data   = req_i.wr & (req_i.addr == `SMSC_OFS_DATA);
   wire        rd_data   = req_i.rd & (req_i.addr == `SMSC_OFS_DATA);
   wire        wr_match  = req_i.wr & (req_i.addr == `SMSC_OFS_MATCH);
   wire        wr_ctrl   = req_i.wr & (req_i.addr == `SMSC_OFS_CTRL);
   wire        rd_match  = req_i.rd & (req_i.addr == `SMSC_OFS_MATCH);
   wire        rd_ctrl   = req_i.rd & (req_i.addr == `SMSC_OFS_CTRL);

   wire        en        = ctrl_q.enable;
   wire        master    = ctrl_q.master;
   wire        ss_act    = ~slave_select_n_i;
   wire        slave_end = ~en | master | ~ss_act;
   wire        in_master = (st_q == ST_MASTER);
   wire        in_cmp    = (st_q == ST_CMP);
   wire        in_data   = (st_q == ST_DATA);
   wire        moving    = in_master | in_cmp | in_data;

   // Edge sources: own generated clock as master, pin as slave
   wire        m_rise    = tick & ~sck_q;
   wire        m_fall    = tick & sck_q;
   wire        s_rise    = serial_clock_pin_i & ~sck_prev_q;
   wire        s_fall    = ~serial_clock_pin_i & sck_prev_q;
   wire        rise      = in_master ? m_rise : s_rise;
   wire        fall      = in_master ? m_fall : s_fall;
   wire        samp_edge = moving & (ctrl_q.fall_samp ? fall : rise);
   wire        drv_edge  = moving & (ctrl_q.fall_samp ? rise : fall);

   // Byte assembly, most significant bit first
   wire [7:0]  byte_in   = {sh_q[6:0], serial_input_pin_i};
   wire        byte_done = samp_edge & (bits_q == `SMSC_LAST_BIT);
   wire        cmp_done  = byte_done & in_cmp;
   wire        is_match  = (byte_in == match_q);
   wire        data_done = byte_done & (in_master | in_data);
   wire        ovr_set   = data_done & ~in_master & ctrl_q.rx_ready
                           & ~rd_data;
   wire        m_last    = in_master & tick & (edges_q == `SMSC_LAST_EDGE);
   // A data write while a master byte is still moving is ignored
   wire        m_start   = en & master & wr_data & ~in_master;
   wire        sh_load   = wr_data & ~in_master;
   wire        s_start   = en & ~master & ss_act;

   // Next control value
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d.enable    = req_i.wdata[`SMSC_B_ENABLE];
         ctrl_d.dout_off  = req_i.wdata[`SMSC_B_DOUT_OFF];
         ctrl_d.cmp_en    = req_i.wdata[`SMSC_B_CMP_EN];
         ctrl_d.fall_samp = req_i.wdata[`SMSC_B_FALL_SAMP];
         ctrl_d.timer_src = req_i.wdata[`SMSC_B_TIMER_SRC];
         ctrl_d.master    = req_i.wdata[`SMSC_B_MASTER];
         if (master) begin
            ctrl_d.overrun = req_i.wdata[`SMSC_B_OVERRUN];
         end else begin
            ctrl_d.overrun = ctrl_q.overrun & req_i.wdata[`SMSC_B_OVERRUN];
         end
      end
      if (ovr_set) begin
         ctrl_d.overrun = 1'b1;
      end
      // A byte landing in the same cycle as a read keeps the flag set
      ctrl_d.rx_ready = data_done | (ctrl_q.rx_ready & ~rd_data);
   end

   // Transfer sequencing
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: begin
            if (m_start) begin
               st_d = ST_MASTER;
            end else if (s_start) begin
               st_d = ctrl_q.cmp_en ? ST_CMP : ST_DATA;
            end
         end
         ST_MASTER: begin
            if (!en || m_last) begin
               st_d = ST_IDLE;
            end
         end
         ST_CMP: begin
            if (slave_end) begin
               st_d = ST_IDLE;
            end else if (cmp_done) begin
               st_d = is_match ? ST_DATA : ST_IGNORE;
            end
         end
         ST_DATA: begin
            if (slave_end) begin
               st_d = ST_IDLE;
            end
         end
         ST_IGNORE: begin
            if (slave_end) begin
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   // Output drive enables and read data
   wire        dout_oe_d = en & (master | (in_data & ~ctrl_q.dout_off));
   wire        sck_oe_d  = en & master;
   wire [7:0]  rd_mux    = rd_data  ? receive_holding_buffer_q :
                           rd_match ? match_q :
                           rd_ctrl  ? ctrl_q  : `SMSC_BYTE_RESET;
   wire        any_rd    = req_i.rd;

   smsc_clk_gen u_clk_gen (
      .sys_clk_i   (sys_clk_i),
      .resetn_i    (resetn_i),
      .run_i       (in_master),
      .use_timer_i (ctrl_q.timer_src),
      .rate_i      ({ctrl_q.dout_off, ctrl_q.overrun}),
      .timer_i     (timer_zero_output_i),
      .tick_o      (tick)
   );

   // Registers and state
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q  <= `SMSC_CTRL_RESET;
         st_q    <= ST_IDLE;
         match_q <= `SMSC_BYTE_RESET;
         receive_holding_buffer_q <= `SMSC_BYTE_RESET;
      end else begin
         ctrl_q  <= ctrl_d;
         st_q    <= st_d;
         if (wr_match) begin
            match_q <= req_i.wdata;
         end
         if (data_done) begin
            receive_holding_buffer_q <= byte_in;
         end
      end
   end

   // Shift register and bit counting
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sh_q   <= `SMSC_BYTE_RESET;
         samp_q <= 1'b0;
         pend_q <= 1'b0;
         bits_q <= 3'h0;
         dout_q <= 1'b0;
      end else if (sh_load || m_start) begin
         sh_q   <= req_i.wdata;
         dout_q <= req_i.wdata[7];
         pend_q <= 1'b0;
         bits_q <= in_master ? bits_q : 3'h0;
      end else if (!moving) begin
         pend_q <= 1'b0;
         bits_q <= 3'h0;
      end else if (samp_edge) begin
         samp_q <= serial_input_pin_i;
         pend_q <= 1'b1;
         bits_q <= bits_q + 3'h1;
      end else if (drv_edge && pend_q) begin
         sh_q   <= {sh_q[6:0], samp_q};
         dout_q <= sh_q[6];
         pend_q <= 1'b0;
      end
   end

   // Master clock generation
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sck_q      <= 1'b0;
         edges_q    <= 4'h0;
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= serial_clock_pin_i;
         if (!in_master) begin
            sck_q   <= 1'b0;
            edges_q <= 4'h0;
         end else if (tick) begin
            sck_q   <= ~sck_q;
            edges_q <= edges_q + 4'h1;
         end
      end
   end

   // Pin and event outputs
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dout_oe_q <= 1'b0;
         sck_oe_q  <= 1'b0;
         rdata_q   <= `SMSC_BYTE_RESET;
         irq_q     <= 1'b0;
         wake_q    <= 1'b0;
      end else begin
         dout_oe_q <= dout_oe_d;
         sck_oe_q  <= sck_oe_d;
         irq_q     <= data_done;
         wake_q    <= cmp_done & is_match;
         if (any_rd) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign pins_o.dout                 = dout_q;
   assign pins_o.dout_oe              = dout_oe_q;
   assign pins_o.sck                  = sck_q;
   assign pins_o.sck_oe               = sck_oe_q;
   assign rdata_o                     = rdata_q;
   assign receive_interrupt_request_o = irq_q;
   assign stop_wake_signal_o          = wake_q;

endmodule : smsc_core

// file: logic/smsc_defines.svh
// Register offsets, bit positions and counts of the serial interface
`ifndef SMSC_DEFINES_SVH
`define SMSC_DEFINES_SVH

`define SMSC_OFS_DATA    8'h00
`define SMSC_OFS_MATCH   8'h01
`define SMSC_OFS_CTRL    8'h02

`define SMSC_B_ENABLE    0
`define SMSC_B_OVERRUN   1
`define SMSC_B_DOUT_OFF  2
`define SMSC_B_CMP_EN    3
`define SMSC_B_RX_READY  4
`define SMSC_B_FALL_SAMP 5
`define SMSC_B_TIMER_SRC 6
`define SMSC_B_MASTER    7

`define SMSC_CTRL_RESET  8'h00
`define SMSC_BYTE_RESET  8'h00

`define SMSC_HALF_DIV2   3'h0
`define SMSC_HALF_DIV4   3'h1
`define SMSC_HALF_DIV8   3'h3
`define SMSC_HALF_DIV16  3'h7

`define SMSC_RATE_DIV2   2'h0
`define SMSC_RATE_DIV4   2'h1
`define SMSC_RATE_DIV8   2'h2

`define SMSC_LAST_BIT    3'h7
`define SMSC_LAST_EDGE   4'hf

`endif

// file: logic/smsc_pkg.sv
// Types shared by the serial interface modules
package smsc_pkg;

   typedef struct packed {
      logic       master;
      logic       timer_src;
      logic       fall_samp;
      logic       rx_ready;
      logic       cmp_en;
      logic       dout_off;
      logic       overrun;
      logic       enable;
   } smsc_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smsc_req_t;

   typedef struct packed {
      logic       dout;
      logic       dout_oe;
      logic       sck;
      logic       sck_oe;
   } smsc_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MASTER,
      ST_CMP,
      ST_DATA,
      ST_IGNORE
   } smsc_state_t;

endpackage : smsc_pkg

// file: test/smsc_core_sva.sv
// Port assertions and covers for the serial interface core
`include "smsc_defines.svh"

module smsc_core_sva
   import smsc_pkg::*;
(
   input wire logic       sys_clk_i,
   input wire logic       resetn_i,
   input smsc_req_t       req_i,
   input wire logic [7:0] rdata_o,
   input wire logic       slave_select_n_i,
   input smsc_pins_t      pins_o,
   input wire logic       receive_interrupt_request_o,
   input wire logic       stop_wake_signal_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   wire irq = receive_interrupt_request_o;
   wire wk  = stop_wake_signal_o;
   wire rdd = req_i.rd && (req_i.addr == `SMSC_OFS_DATA);
   wire rdc = req_i.rd && (req_i.addr == `SMSC_OFS_CTRL);
   property p_irq_pulse; irq |=> !irq; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_wake_pulse; wk |=> !wk; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
   property p_wake_quiet; wk |-> !irq; endproperty
   a_wake_quiet: assert property (p_wake_quiet) else $error("irq on compare");
   property p_ready_clr; rdd ##1 (rdc && !irq) |=> !rdata_o[`SMSC_B_RX_READY]; endproperty
   a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");
   property p_hold; !req_i.rd |=> $stable(rdata_o); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_release;
      $rose(slave_select_n_i) && !pins_o.sck_oe |-> ##[1:3] !pins_o.dout_oe;
   endproperty
   a_release: assert property (p_release) else $error("data out kept");
   property p_sck_idle; !pins_o.sck_oe |-> !pins_o.sck; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock not idle");
   property p_oe_master; pins_o.sck_oe |-> pins_o.dout_oe; endproperty
   a_oe_master: assert property (p_oe_master) else $error("master data off");
   c_irq: cover property (irq);
   c_wake: cover property (wk);
   c_sck: cover property ($rose(pins_o.sck));
endmodule : smsc_core_sva

bind smsc_core smsc_core_sva i_smsc_core_sva (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
   .slave_select_n_i(slave_select_n_i), .pins_o(pins_o),
   .receive_interrupt_request_o(receive_interrupt_request_o),
   .stop_wake_signal_o(stop_wake_signal_o)
);

// file: test/smsc_far_end.sv
// Far-end serial master driving the slave side of the core
module smsc_far_end (
   input  wire logic sys_clk_i,
   input  wire logic dout_i,
   output logic      sck_o,
   output logic      ss_n_o,
   output logic      mosi_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b1;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tk
   // One byte MSB first, data held across both clock edges
   task automatic xfer(input logic [7:0] tx, input logic fall, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         ss_n_o = 1'b0;
         mosi_o = tx[i];
         tk(4);
         if (!fall) rx[i] = dout_i;
         sck_o = 1'b1;
         tk(4);
         if (fall) rx[i] = dout_i;
         sck_o = 1'b0;
         tk(4);
         mosi_o = ~tx[i];
      end
   endtask : xfer
   task automatic release_ss();
      tk(4);
      ss_n_o = 1'b1;
   endtask : release_ss
endmodule : smsc_far_end

// file: test/tb_top.sv
// Self-checking bench for the serial interface core
`include "smsc_defines.svh"

module tb_top
   import smsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk, resetn, timer, irq, wake, f_sck, f_ss_n, f_mosi, sck_q;
   smsc_req_t  req;
   smsc_pins_t pins;
   logic [7:0] rdata, m_ctl, m_buf, c, d, t, mv;
   logic [7:0] md [3] = '{8'h01, 8'h21, 8'h05};
   int fails, checks_done, m_rdy, m_ovr, cyc, irq_n, wake_n, oe_n, rise_n, r_first, r_last;
   wire        din = m_ctl[7] ? pins.dout : f_mosi;

   smsc_core i_smsc_core (
      .sys_clk_i(sys_clk), .resetn_i(resetn), .req_i(req), .rdata_o(rdata),
      .serial_input_pin_i(din), .serial_clock_pin_i(f_sck), .slave_select_n_i(f_ss_n),
      .timer_zero_output_i(timer), .pins_o(pins),
      .receive_interrupt_request_o(irq), .stop_wake_signal_o(wake));
   smsc_far_end i_smsc_far_end (
      .sys_clk_i(sys_clk), .dout_i(pins.dout), .sck_o(f_sck), .ss_n_o(f_ss_n),
      .mosi_o(f_mosi));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      timer <= cyc[1];
      irq_n += irq;
      wake_n += wake;
      oe_n += pins.dout_oe;
      if (pins.sck && !sck_q) begin
         if (rise_n == 0) r_first = cyc;
         r_last = cyc;
         rise_n++;
      end
      sck_q = pins.sck;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tk
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chkn(input string nm, input int e, input int g);
      checks_done++;
      if (g != e) begin
         fails++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chkn
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req.addr = a;
      req.wdata = v;
      req.wr = 1'b1;
      tk(1);
      req.wr = 1'b0;
      tk(1);
   endtask : wr
   task automatic rd2(input logic [7:0] a0, a1, output logic [7:0] v0, v1);
      req.addr = a0;
      req.rd = 1'b1;
      tk(1);
      v0 = rdata;
      req.addr = a1;
      tk(1);
      v1 = rdata;
      req.rd = 1'b0;
      tk(1);
   endtask : rd2
   // Model of the receive buffer and its flags
   task automatic mrx(input logic [7:0] b);
      if (m_rdy != 0 && !m_ctl[7]) m_ovr = 1;
      m_rdy = 1;
      m_buf = b;
   endtask : mrx
   function automatic logic [7:0] mctl();
      return m_ctl | 8'(m_rdy << 4) | 8'(m_ovr << 1);
   endfunction : mctl
   task automatic pair(input logic [7:0] b0, b1, tx);
      logic [7:0] g;
      i_smsc_far_end.xfer(b0, m_ctl[5], g);
      if (m_ctl == 8'h01) chk("dout", tx, g);
      i_smsc_far_end.xfer(b1, m_ctl[5], g);
      i_smsc_far_end.release_ss();
   endtask : pair
   task automatic give_verdict();
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hec30_a49b));
      {resetn, timer, sck_q, m_rdy, m_ovr, cyc, rise_n} = '0;
      req = '0;
      m_ctl = 8'h00;
      tk(3);
      resetn = 1'b1;
      rd2(`SMSC_OFS_CTRL, 8'h05, c, d);
      chk("ctrl_reset", `SMSC_CTRL_RESET, c);
      chk("unmapped", 8'h00, d);
      t = 8'($urandom) | 8'h80;
      // Second write lands in master mode, where bit 1 is a plain rate bit
      wr(`SMSC_OFS_CTRL, t);
      wr(`SMSC_OFS_CTRL, t);
      rd2(`SMSC_OFS_CTRL, `SMSC_OFS_CTRL, c, d);
      chk("ctrl_rw", t & 8'hef, c);
      wr(`SMSC_OFS_CTRL, 8'h00);
      foreach (md[k]) begin
         m_ctl = md[k];
         wr(`SMSC_OFS_CTRL, m_ctl);
         t = 8'($urandom);
         wr(`SMSC_OFS_DATA, t);
         {irq_n, oe_n} = '0;
         c = 8'($urandom);
         d = 8'($urandom);
         pair(c, d, t);
         mrx(c);
         mrx(d);
         chkn("irq", 2, irq_n);
         chkn("dout_oe", int'(!m_ctl[2]), int'(oe_n > 0));
         rd2(`SMSC_OFS_CTRL, `SMSC_OFS_DATA, c, d);
         chk("ctrl_ovr", mctl(), c);
         chk("receive_holding_buffer", m_buf, d);
         m_rdy = 0;
         wr(`SMSC_OFS_CTRL, m_ctl);
         m_ovr = 0;
         rd2(`SMSC_OFS_DATA, `SMSC_OFS_CTRL, d, c);
         chk("ctrl_clr", mctl(), c);
      end
      m_ctl = 8'h09;
      wr(`SMSC_OFS_CTRL, m_ctl);
      mv = 8'($urandom);
      wr(`SMSC_OFS_MATCH, mv);
      for (int j = 0; j < 2; j++) begin
         {irq_n, wake_n, oe_n} = '0;
         t = 8'($urandom);
         pair(mv ^ 8'(j), t, t);
         if (j == 0) mrx(t);
         chkn("wake", 1 - j, wake_n);
         chkn("cmp_irq", 1 - j, irq_n);
         chkn("cmp_oe", 1 - j, int'(oe_n > 0));
         rd2(`SMSC_OFS_CTRL, `SMSC_OFS_DATA, c, d);
         chk("cmp_ctrl", mctl(), c);
         chk("cmp_buf", m_buf, d);
         m_rdy = 0;
      end
      for (int k = 0; k < 5; k++) begin
         m_ctl = 8'h81 | (8'(k % 4) << 1) | (k == 4 ? 8'h40 : 8'h00);
         wr(`SMSC_OFS_CTRL, m_ctl);
         {irq_n, rise_n} = '0;
         t = 8'($urandom);
         wr(`SMSC_OFS_DATA, t);
         for (int w = 0; w < 300 && irq_n == 0; w++) tk(1);
         tk(4);
         mrx(t);
         chkn("sck_rises", 8, rise_n);
         chkn("sck_span", 7 * (k == 4 ? 8 : 2 << k), r_last - r_first);
         rd2(`SMSC_OFS_DATA, `SMSC_OFS_CTRL, d, c);
         chk("m_buf", m_buf, d);
         m_rdy = 0;
         chk("m_ctrl", mctl(), c);
      end
      give_verdict();
   end
endmodule : tb_top
